// File: logic/timer_pulse_acc.sv
/*
  Pulse accumulator flags and count, test bypass, timer port data and
  direction, and low-power/debug halting, behind a classic Wishbone slave.
  Assumes compare channels, main counter and prescaler live elsewhere and
  supply oc_enable_i/oc_level_i on this clock; mode inputs share the clock.
*/
// Notes on behaviour
// - Input edge interrupt requested while edge flag and its enable are set.
// - With fast clear on, any count access clears all accumulator flags.
// - Overflow flag sets when the 16-bit count wraps from ffff to 0000.
// - Writing one to flag bit 1 clears the overflow flag.
// - Edge flag sets on counted edge, or trailing gate edge in gated mode.
// - Writing one to flag bit 0 clears the edge flag.
// - Test register always readable, writable only while special-mode-low is 0.
// - Counter bypass bit splits main counter into directly clocked halves.
// - Accumulator bypass splits count into two directly clocked 8-bit halves.
// - Port reads give pin level for inputs, driver level for outputs.
// - Port writes go to a latch that drives only general-purpose outputs.
// - Direction bit 0 makes a pin input, 1 makes it output.
// - Enabled output compare forces output without changing the direction bit.
// - Input capture channels leave the programmed direction alone.
// - Stop mode halts the whole timer.
// - In debug the timer runs unless debug-stop is set.
// - In wait the counters run unless wait-stop is set.
// - Timer enable low halts the main timer and the divide-by-64 clock; accumulator edge counting goes on.
// - Accumulator enable low halts all accumulator operation.
// - Overflow interrupt requested while overflow flag and its enable are set.
// - Gated mode with edge bit 0 counts divide-by-64 ticks while input high.
`timescale 1ns/1ns
`default_nettype none

module timer_pulse_acc #(
  parameter int ADDR_W = 10
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic [7:0]        port_pin_i,
  output logic      [7:0]        port_pin_o,
  output logic      [7:0]        port_oe_n_o,
  input  wire logic [7:0]        oc_enable_i,
  input  wire logic [7:0]        oc_level_i,
  input  wire logic              special_mode_low_i,
  input  wire logic              stop_mode_i,
  input  wire logic              wait_mode_i,
  input  wire logic              background_debug_state_i,
  output logic                   acc_input_irq_o,
  output logic                   acc_overflow_irq_o,
  output logic                   timer_active_o,
  output logic                   fast_flag_clear_all_o,
  output logic                   counter_divider_bypass_o
);

  // ----------------------------------------------------------------
  // Registers and synchronised inputs
  // ----------------------------------------------------------------
  logic [7:0]  acc_control_r;
  logic [1:0]  pulse_acc_flags_r;
  logic [15:0] pulse_acc_count_r;
  logic [7:0]  timer_system_control_r;
  logic [7:0]  timer_test_control_r;
  logic [7:0]  timer_port_pin_data_r;
  logic [7:0]  timer_port_direction_r;
  logic [5:0]  div64_r;
  logic        acc_in_prev_r;
  logic        ack_r;
  logic [31:0] rdata_r;
  logic [8:0]  sync_level;

  pin_sync #(
    .W (9)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i ({special_mode_low_i, port_pin_i}),
    .level_o (sync_level)
  );

  wire [7:0] pin_level  = sync_level[7:0];
  wire       smode_low  = sync_level[8];
  wire       acc_in_level = pin_level[timer_pacc_pkg::PIN_ACC_INPUT];

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire       req      = wb_cyc_i & wb_stb_i;
  wire       take     = req & ~ack_r;
  wire       done     = req & ack_r;
  wire [7:0] idx      = wb_adr_i[ADDR_W-1:2];
  wire       wr       = done & wb_we_i;
  wire       hit_ctl  = idx == timer_pacc_pkg::IDX_ACC_CONTROL;
  wire       hit_flg  = idx == timer_pacc_pkg::IDX_ACC_FLAGS;
  wire       hit_cnt  = idx == timer_pacc_pkg::IDX_ACC_COUNT;
  wire       hit_sys  = idx == timer_pacc_pkg::IDX_SYS_CONTROL;
  wire       hit_tst  = idx == timer_pacc_pkg::IDX_TEST_CONTROL;
  wire       hit_prt  = idx == timer_pacc_pkg::IDX_PORT_DATA;
  wire       hit_dir  = idx == timer_pacc_pkg::IDX_PORT_DIR;
  wire       lane0    = wb_sel_i[0];
  wire       lane1    = wb_sel_i[1];
  wire [7:0] wbyte0   = wb_dat_i[7:0];
  wire [7:0] wbyte1   = wb_dat_i[15:8];

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  wire acc_system_enable     = acc_control_r[timer_pacc_pkg::BIT_ACC_ENABLE];
  wire acc_gated_mode_select = acc_control_r[timer_pacc_pkg::BIT_ACC_GATED];
  wire acc_edge_select       = acc_control_r[timer_pacc_pkg::BIT_ACC_EDGE];
  wire acc_overflow_irq_en   = acc_control_r[timer_pacc_pkg::BIT_ACC_OVF_IRQ_EN];
  wire acc_input_irq_enable  = acc_control_r[timer_pacc_pkg::BIT_ACC_IN_IRQ_EN];
  wire timer_enable_bit      = timer_system_control_r[timer_pacc_pkg::BIT_TIMER_ENABLE];
  wire wait_stop_timer       = timer_system_control_r[timer_pacc_pkg::BIT_WAIT_STOP];
  wire debug_stop_timer      = timer_system_control_r[timer_pacc_pkg::BIT_DEBUG_STOP];
  wire fast_clear            = timer_system_control_r[timer_pacc_pkg::BIT_FAST_CLEAR];
  wire cnt_bypass            = timer_test_control_r[timer_pacc_pkg::BIT_CNT_BYPASS];
  wire acc_bypass            = timer_test_control_r[timer_pacc_pkg::BIT_ACC_BYPASS];

  // ----------------------------------------------------------------
  // Run conditions and divide-by-64 tick
  // ----------------------------------------------------------------
  // Mode halting
  wire run_ok       = ~stop_mode_i & ~(wait_mode_i & wait_stop_timer)
                    & ~(background_debug_state_i & debug_stop_timer);
  wire timer_active = timer_enable_bit & run_ok;
  wire acc_active   = acc_system_enable & run_ok;
  wire div_tick     = timer_active & (acc_bypass | (div64_r == timer_pacc_pkg::DIV64_LAST));

  // ----------------------------------------------------------------
  // Accumulator counting
  // ----------------------------------------------------------------
  wire rise       = acc_in_level & ~acc_in_prev_r;
  wire fall       = ~acc_in_level & acc_in_prev_r;
  wire sel_edge   = acc_edge_select ? rise : fall;
  // Gate open on high level with edge bit 0, low level with edge bit 1
  wire gate_open  = acc_in_level ^ acc_edge_select;
  wire inc        = acc_active & (acc_gated_mode_select ? (gate_open & div_tick) : sel_edge);
  // Same edge marks counted event and trailing gate edge
  wire edge_set   = acc_active & sel_edge;
  wire [7:0] hi_inc = pulse_acc_count_r[15:8] + 8'h01;
  wire [7:0] lo_inc = pulse_acc_count_r[7:0] + 8'h01;
  // Bypass clocks both halves with no carry between them
  wire [15:0] count_inc = acc_bypass ? {hi_inc, lo_inc} : pulse_acc_count_r + 16'h0001;
  wire ovf_set    = inc & (acc_bypass ? (pulse_acc_count_r[15:8] == 8'hff)
                                      : (pulse_acc_count_r == 16'hffff));
  wire cnt_write  = wr & hit_cnt;
  wire [15:0] count_wval = {lane1 ? wbyte1 : pulse_acc_count_r[15:8],
                            lane0 ? wbyte0 : pulse_acc_count_r[7:0]};
  wire [15:0] count_nxt  = cnt_write ? count_wval : (inc ? count_inc : pulse_acc_count_r);

  // ----------------------------------------------------------------
  // Flags: set wins over clear
  // ----------------------------------------------------------------
  // Fast clear on any count access
  wire ffca_clr   = done & hit_cnt & fast_clear;
  wire [1:0] w1c  = (wr & hit_flg & lane0) ? wbyte0[1:0] : 2'h0;
  wire [1:0] clr  = w1c | {2{ffca_clr}};
  wire [1:0] setv = {ovf_set, edge_set};
  wire [1:0] flags_nxt = setv | (pulse_acc_flags_r & ~clr);
  wire       edge_flag = pulse_acc_flags_r[timer_pacc_pkg::BIT_FLAG_EDGE];
  wire       ovf_flag  = pulse_acc_flags_r[timer_pacc_pkg::BIT_FLAG_OVF];

  // ----------------------------------------------------------------
  // Timer port
  // ----------------------------------------------------------------
  // Compare enable forces output, direction bit kept
  wire [7:0] out_dir   = oc_enable_i | timer_port_direction_r;
  wire [7:0] drive_lvl = (oc_enable_i & oc_level_i) | (~oc_enable_i & timer_port_pin_data_r);
  // Read back pin or driver level
  wire [7:0] port_read = (out_dir & drive_lvl) | (~out_dir & pin_level);

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  wire [31:0] rdata_nxt =
      hit_ctl ? {24'h000000, acc_control_r} :
      hit_flg ? {30'h00000000, pulse_acc_flags_r} :
      hit_cnt ? {16'h0000, pulse_acc_count_r} :
      hit_sys ? {24'h000000, timer_system_control_r} :
      // Test register readable at any time
      hit_tst ? {24'h000000, timer_test_control_r} :
      hit_prt ? {24'h000000, port_read} :
      hit_dir ? {24'h000000, timer_port_direction_r} : 32'h00000000;

  // Test writes only in special mode
  wire tst_write = wr & hit_tst & lane0 & ~smode_low;

  // ----------------------------------------------------------------
  // Register updates
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h00000000;
    end else begin
      ack_r   <= take;
      rdata_r <= take ? rdata_nxt : 32'h00000000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_control_r          <= timer_pacc_pkg::RST_BYTE;
      timer_system_control_r <= timer_pacc_pkg::RST_BYTE;
      timer_test_control_r   <= timer_pacc_pkg::RST_BYTE;
      timer_port_pin_data_r  <= timer_pacc_pkg::RST_BYTE;
      timer_port_direction_r <= timer_pacc_pkg::RST_BYTE;
    end else begin
      if (wr & hit_ctl & lane0) acc_control_r <= wbyte0;
      if (wr & hit_sys & lane0) timer_system_control_r <= wbyte0;
      if (tst_write) timer_test_control_r <= wbyte0;
      if (wr & hit_prt & lane0) timer_port_pin_data_r <= wbyte0;
      if (wr & hit_dir & lane0) timer_port_direction_r <= wbyte0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pulse_acc_flags_r <= 2'h0;
      pulse_acc_count_r <= timer_pacc_pkg::RST_COUNT;
      div64_r           <= timer_pacc_pkg::DIV64_RST;
      acc_in_prev_r     <= 1'b0;
    end else begin
      pulse_acc_flags_r <= flags_nxt;
      pulse_acc_count_r <= count_nxt;
      // Divider frozen while the timer is halted
      if (timer_active) div64_r <= div64_r + 6'h01;
      acc_in_prev_r     <= acc_in_level;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_pin_o               <= 8'h00;
      port_oe_n_o              <= 8'hff;
      acc_input_irq_o          <= 1'b0;
      acc_overflow_irq_o       <= 1'b0;
      timer_active_o           <= 1'b0;
      fast_flag_clear_all_o    <= 1'b0;
      counter_divider_bypass_o <= 1'b0;
    end else begin
      port_pin_o               <= drive_lvl;
      port_oe_n_o              <= ~out_dir;
      acc_input_irq_o          <= edge_flag & acc_input_irq_enable;
      acc_overflow_irq_o       <= ovf_flag & acc_overflow_irq_en;
      timer_active_o           <= timer_active;
      fast_flag_clear_all_o    <= fast_clear;
      // Split request to the main counter
      counter_divider_bypass_o <= cnt_bypass;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdata_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ovf_wrap_set: assert property (
    (inc & ~acc_bypass & ~cnt_write & pulse_acc_count_r == 16'hffff)
      |=> (pulse_acc_flags_r[1] & pulse_acc_count_r == 16'h0000))
    else $error("overflow flag not set on wrap");

  a_fast_clear_all: assert property (
    (ffca_clr & ~ovf_set & ~edge_set) |=> (pulse_acc_flags_r == 2'h0))
    else $error("fast clear left a flag set");

  a_ovf_w1c_clear: assert property (
    (wr & hit_flg & lane0 & wbyte0[1] & ~ovf_set) |=> ~pulse_acc_flags_r[1])
    else $error("overflow flag not cleared");

  a_edge_flag_set: assert property (
    edge_set |=> pulse_acc_flags_r[0])
    else $error("edge flag missed");

  a_flag_zero_keep: assert property (
    (pulse_acc_flags_r[0] & wr & hit_flg & ~wbyte0[0] & ~ffca_clr) |=> pulse_acc_flags_r[0])
    else $error("zero write cleared a flag");

  a_input_irq_req: assert property (
    (pulse_acc_flags_r[0] & acc_input_irq_enable) ##1 pulse_acc_flags_r[0] |-> acc_input_irq_o)
    else $error("edge interrupt not requested");

  a_test_write_lock: assert property (
    (wr & hit_tst & smode_low) |=> $stable(timer_test_control_r))
    else $error("test register written outside special mode");

  a_oc_forces_out: assert property (
    oc_enable_i[4] |=> (~port_oe_n_o[4] & port_pin_o[4] == $past(oc_level_i[4])))
    else $error("compare did not take pin");

  a_dir_sets_pin: assert property (
    ~oc_enable_i[3] |=> (port_oe_n_o[3] == ~$past(timer_port_direction_r[3])))
    else $error("direction bit not applied to pin");

  a_ovf_irq_req: assert property (
    (ovf_flag & acc_overflow_irq_en) |=> acc_overflow_irq_o)
    else $error("overflow interrupt not requested");

  a_acc_halted: assert property (
    (~acc_active & ~cnt_write) |=> $stable(pulse_acc_count_r))
    else $error("count moved while halted");

  a_div_halted: assert property (
    ~timer_active |=> $stable(div64_r))
    else $error("divide tick while timer halted");

  a_bypass_halves: assert property (
    (inc & acc_bypass & ~cnt_write & pulse_acc_count_r[7:0] == 8'hff)
      |=> (pulse_acc_count_r[15:8] == ($past(pulse_acc_count_r[15:8]) + 8'h01)
           & pulse_acc_count_r[7:0] == 8'h00))
    else $error("bypass halves not independent");

  a_ack_single: assert property (
    wb_ack_o |=> ~wb_ack_o)
    else $error("ack held longer than one cycle");

  c_gated_count: cover property (acc_gated_mode_select & inc);
  c_ovf_wrap: cover property (ovf_set);
  c_fast_clear: cover property (ffca_clr & (pulse_acc_flags_r != 2'h0));
  c_bypass_inc: cover property (acc_bypass & inc);

endmodule // timer_pulse_acc

`default_nettype wire

// File: logic/timer_pacc_pkg.sv
/*
  Shared constants for the pulse accumulator and timer port block:
  register indices, field positions, reset values and divider counts.
  Assumes a byte address equal to four times the register index.
*/
`default_nettype none

package timer_pacc_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is index times four)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_ACC_CONTROL  = 8'ha0;
  localparam logic [7:0] IDX_ACC_FLAGS    = 8'ha1;
  localparam logic [7:0] IDX_ACC_COUNT    = 8'ha2;
  localparam logic [7:0] IDX_SYS_CONTROL  = 8'ha6;
  localparam logic [7:0] IDX_TEST_CONTROL = 8'had;
  localparam logic [7:0] IDX_PORT_DATA    = 8'hae;
  localparam logic [7:0] IDX_PORT_DIR     = 8'haf;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_ACC_ENABLE     = 6;
  localparam int BIT_ACC_GATED      = 5;
  localparam int BIT_ACC_EDGE       = 4;
  localparam int BIT_ACC_OVF_IRQ_EN = 1;
  localparam int BIT_ACC_IN_IRQ_EN  = 0;
  localparam int BIT_FLAG_OVF       = 1;
  localparam int BIT_FLAG_EDGE      = 0;
  localparam int BIT_TIMER_ENABLE   = 7;
  localparam int BIT_WAIT_STOP      = 6;
  localparam int BIT_DEBUG_STOP     = 5;
  localparam int BIT_FAST_CLEAR     = 4;
  localparam int BIT_CNT_BYPASS     = 2;
  localparam int BIT_ACC_BYPASS     = 1;
  localparam int PIN_ACC_INPUT      = 7;

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0]  RST_BYTE      = 8'h00;
  localparam logic [15:0] RST_COUNT     = 16'h0000;
  localparam logic [5:0]  DIV64_LAST    = 6'h3f;
  localparam logic [5:0]  DIV64_RST     = 6'h00;

endpackage : timer_pacc_pkg

`default_nettype wire

// File: logic/pin_sync.sv
/*
  Two-stage synchroniser for a group of level inputs.
  Assumes each input is a plain level from outside the clock domain.
*/
`timescale 1ns/1ns
`default_nettype none

module pin_sync #(
  parameter int W = 8
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] level_o
);

  logic [W-1:0] stage1_r;
  logic [W-1:0] stage2_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stage1_r <= '0;
      stage2_r <= '0;
    end else begin
      stage1_r <= async_i;
      stage2_r <= stage1_r;
    end
  end

  assign level_o = stage2_r;

endmodule // pin_sync

`default_nettype wire

// File: test/port_far_side.sv
/*
  Far-side model: timer port pins and the accumulator pulse source.
  Assumes the bench calls hold_acc from its clocked sequence.
*/
`timescale 1ns/1ns
`default_nettype none

module port_far_side #(
  parameter logic [6:0] EXT = 7'h2c
) (
  input  wire logic       clk_i,
  input  wire logic [7:0] drv_i,
  input  wire logic [7:0] oe_n_i,
  output logic      [7:0] pin_o
);
  logic acc_r;

  initial acc_r = 1'b1;

  // Driven pins follow the block, released pins the outside source
  assign pin_o = (drv_i & ~oe_n_i) | ({acc_r, EXT} & oe_n_i);

  task automatic hold_acc(input logic lvl, input int cycles);
    @(posedge clk_i);
    acc_r <= lvl;
    repeat ((cycles < 3) ? 3 : cycles) @(posedge clk_i);
  endtask
endmodule // port_far_side

`default_nettype wire

// File: test/timer_pulse_acc_tb.sv
/*
  Self-checking bench for timer_pulse_acc over classic Wishbone.
  Assumes port_far_side models the pins and the pulse source.
*/
`timescale 1ns/1ns
`default_nettype none

module timer_pulse_acc_tb;
  localparam logic [7:0] A_CTL = timer_pacc_pkg::IDX_ACC_CONTROL;
  localparam logic [7:0] A_FLG = timer_pacc_pkg::IDX_ACC_FLAGS;
  localparam logic [7:0] A_CNT = timer_pacc_pkg::IDX_ACC_COUNT;
  localparam logic [7:0] A_SYS = timer_pacc_pkg::IDX_SYS_CONTROL;
  localparam logic [7:0] A_TST = timer_pacc_pkg::IDX_TEST_CONTROL;
  localparam logic [7:0] A_DAT = timer_pacc_pkg::IDX_PORT_DATA;
  localparam logic [7:0] A_DIR = timer_pacc_pkg::IDX_PORT_DIR;
  localparam logic [7:0] SYS_V [7] = '{8'h00, 8'h80, 8'h80, 8'hc0, 8'h80, 8'ha0, 8'h80};
  localparam logic [2:0] MODE_V [7] = '{3'h0, 3'h0, 3'h4, 3'h2, 3'h1, 3'h1, 3'h2};
  localparam logic       ACT_V [7] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};

  logic        clk_i, rst_i, cyc, stb, we, smode_n, stop, wt, dbg;
  logic        ack, irq_in, irq_ovf, active, ffc, cbyp;
  logic [9:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, dat_o;
  logic [7:0]  oc_en, oc_lv, pin, pin_o, oe_n;
  int          fail_count, check_count;

  timer_pulse_acc u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .port_pin_i(pin), .port_pin_o(pin_o), .port_oe_n_o(oe_n),
    .oc_enable_i(oc_en), .oc_level_i(oc_lv), .special_mode_low_i(smode_n),
    .stop_mode_i(stop), .wait_mode_i(wt), .background_debug_state_i(dbg),
    .acc_input_irq_o(irq_in), .acc_overflow_irq_o(irq_ovf),
    .timer_active_o(active), .fast_flag_clear_all_o(ffc),
    .counter_divider_bypass_o(cbyp));

  port_far_side u_far (.clk_i(clk_i), .drv_i(pin_o), .oe_n_i(oe_n), .pin_o(pin));

  // ------------------------------------------------------------
  // Bus and compare tasks
  // ------------------------------------------------------------
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] idx, input logic [15:0] d,
                     input logic [3:0] s);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    sel <= s;
    wdat <= {16'h0000, d};
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, {8'h00, d}, 4'h1);
  endtask

  task automatic chk(input logic [7:0] idx, input logic [15:0] exp);
    bus(1'b0, idx, 16'h0000, 4'h3);
    check(rdat, {16'h0000, exp});
  endtask

  task automatic pulses(input int n);
    repeat (n) begin
      u_far.hold_acc(1'b0, 4);
      u_far.hold_acc(1'b1, 4);
    end
    repeat (6) @(posedge clk_i);
  endtask

  task automatic settle;
    repeat (3) @(posedge clk_i);
  endtask

  // ------------------------------------------------------------
  // Clock, watchdog and test sequence
  // ------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    summarize();
  end

  initial begin
    {cyc, stb, we, stop, wt, dbg} = '0;
    {adr, sel, wdat, oc_en, oc_lv} = '0;
    smode_n = 1'b1;
    fail_count = 0;
    check_count = 0;
    rst_i = 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    check(oe_n, 8'hff);
    chk(A_FLG, 16'h0000);
    chk(A_CNT, 16'h0000);
    wr(8'h10, 8'hff);
    chk(8'h10, 16'h0000);
    wr(A_DIR, 8'h0f);
    wr(A_DAT, 8'h3c);
    settle();
    check(oe_n, 8'hf0);
    check(pin_o[3:0], 4'hc);
    chk(A_DAT, 16'h00ac);
    oc_en <= 8'h30;
    oc_lv <= 8'h10;
    wr(A_DAT, 8'h0c);
    settle();
    check(oe_n, 8'hc0);
    check(pin_o[5:4], 2'b01);
    chk(A_DIR, 16'h000f);
    chk(A_DAT, 16'h009c);
    oc_en <= 8'h00;
    settle();
    check(oe_n, 8'hf0);
    wr(A_CTL, 8'h43);
    pulses(3);
    chk(A_CNT, 16'h0003);
    chk(A_FLG, 16'h0001);
    check(irq_in, 1'b1);
    wr(A_FLG, 8'h00);
    chk(A_FLG, 16'h0001);
    wr(A_FLG, 8'h01);
    chk(A_FLG, 16'h0000);
    check(irq_in, 1'b0);
    bus(1'b1, A_CNT, 16'hffff, 4'h3);
    pulses(1);
    chk(A_CNT, 16'h0000);
    chk(A_FLG, 16'h0003);
    check(irq_ovf, 1'b1);
    wr(A_FLG, 8'h02);
    chk(A_FLG, 16'h0001);
    wr(A_CTL, 8'h03);
    pulses(2);
    chk(A_CNT, 16'h0000);
    wr(A_TST, 8'h06);
    chk(A_TST, 16'h0000);
    smode_n <= 1'b0;
    repeat (4) @(posedge clk_i);
    wr(A_TST, 8'h06);
    chk(A_TST, 16'h0006);
    check(cbyp, 1'b1);
    bus(1'b1, A_CNT, 16'h1234, 4'h3);
    wr(A_CTL, 8'h43);
    pulses(1);
    chk(A_CNT, 16'h1335);
    wr(A_TST, 8'h00);
    for (int i = 0; i < 7; i++) begin
      wr(A_SYS, SYS_V[i]);
      {stop, wt, dbg} <= MODE_V[i];
      settle();
      check(active, ACT_V[i]);
    end
    {stop, wt, dbg} <= 3'h0;
    wr(A_SYS, 8'h80);
    bus(1'b1, A_CNT, 16'h0000, 4'h3);
    wr(A_FLG, 8'h03);
    wr(A_CTL, 8'h60);
    u_far.hold_acc(1'b1, 200);
    u_far.hold_acc(1'b0, 10);
    bus(1'b0, A_CNT, 16'h0000, 4'h3);
    check(rdat >= 32'h3 && rdat <= 32'h4, 1'b1);
    chk(A_FLG, 16'h0001);
    wr(A_SYS, 8'h00);
    bus(1'b1, A_CNT, 16'h0000, 4'h3);
    u_far.hold_acc(1'b1, 200);
    u_far.hold_acc(1'b0, 10);
    chk(A_CNT, 16'h0000);
    wr(A_FLG, 8'h03);
    wr(A_SYS, 8'h90);
    wr(A_CTL, 8'h43);
    u_far.hold_acc(1'b1, 4);
    pulses(1);
    check(ffc, 1'b1);
    chk(A_FLG, 16'h0001);
    chk(A_CNT, 16'h0001);
    chk(A_FLG, 16'h0000);
    summarize();
  end
endmodule // timer_pulse_acc_tb

`default_nettype wire
